// File: dir_pkg.sv
// Purpose: Shared constants for the converter readback two-wire link.
// Assumes: One system clock; the slave oversamples both bus lines, the master only the data line.
// Notes: Address, control byte and readback byte layouts live here.
package dir_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  localparam int ADDR_RW_BIT = 0;
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_LOAD_LSB = 4;
  localparam logic [1:0] CTRL_TOP_ZERO = 2'h0;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [5:0] PD_BYTE_FILL = 6'h3f;
  localparam logic [3:0] LOW_NIBBLE_FILL = 4'h0;
  localparam int CHAN_REG_W = 14;
  localparam int CHAN_COUNT = 4;
  localparam int SCL_HALF_NS = 1250;
  localparam int CLK_NS = 20;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
endpackage : dir_pkg

// File: dir_bus_if.sv
// Purpose: Two-wire bus between master and converter slave.
// Assumes: Open-drain lines; a released line reads high.
// Notes: The wire levels are resolved here from the output enables.
`timescale 1ns/10ps
`default_nettype none
interface dir_bus_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Lines are pulled up and pulled low by any enabled driver.
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_oe, input scl, input sda);
endinterface : dir_bus_if
`default_nettype wire

// File: dir_slave.sv
// Purpose: Converter readback slave on the two-wire bus.
// Assumes: Bus lines oversampled through two flip-flops.
// Notes: Only the readback path is built; the serial clock is never held.
// Operation
// - Write address byte acknowledged by slave
// - Control byte follows and is acknowledged
// - Control byte fields: zeros, load, select, flag
// - Repeated start, read address, slave transmits
// - Address is 10011, two pins, direction
// - Read returns channel chosen by control
// - Flag clear sends high then low byte
// - Flag set sends power byte first
// - High byte bits 11-4, low upper nibble
// - Power byte: two mode bits, six ones
// - Master acks all but last byte
// - Master prefers repeated start after read; dir_master sends a stop
// - High-speed master code is never acknowledged
// - After code, normal sequence at high speed; dir_master keeps the same half period
// - Channels hold 14-bit temp and output registers
// - Slave never drives the serial clock
// Ports: two-wire bus via slave modport; pins and channel loads on user side.
`timescale 1ns/10ps
`default_nettype none
module dir_slave #(
  parameter int CHANNELS = dir_pkg::CHAN_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  dir_bus_if.slave bus,
  input wire logic i_addr_pin_hi,
  input wire logic i_addr_pin_lo,
  input wire logic [1:0] i_load_sel,
  input wire logic i_load_temp,
  input wire logic i_load_output,
  input wire logic [dir_pkg::CHAN_REG_W-1:0] i_load_value,
  output logic [1:0] o_channel_sel,
  output logic o_powerdown_flag,
  output logic [1:0] o_load_mode,
  output logic o_reading
);
  import dir_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_MACK = 6'h10,
    ST_IGNORE = 6'h20
  } dir_state_type;

  dir_state_type state_q;
  logic [1:0] scl_meta_q, sda_meta_q;
  logic scl_q, sda_q, scl_p_q, sda_p_q;
  logic [3:0] pins_meta_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] phase_q;
  logic is_read_q;
  logic [1:0] tx_left_q;
  logic [1:0] tx_idx_q;
  logic sda_oe_q;
  logic [1:0] sel_q;
  logic pd_q;
  logic [1:0] load_q;
  logic [CHAN_REG_W-1:0] temp_channel_reg [CHANNELS];
  logic [CHAN_REG_W-1:0] output_channel_reg [CHANNELS];

  // Two-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      pins_meta_q <= 4'h0;
    end
    else
    begin
      scl_meta_q <= {scl_meta_q[0], bus.scl};
      sda_meta_q <= {sda_meta_q[0], bus.sda};
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
      pins_meta_q <= {pins_meta_q[1:0], i_addr_pin_hi, i_addr_pin_lo};
    end
  end
  assign scl_q = scl_meta_q[1];
  assign sda_q = sda_meta_q[1];

  // Bus events seen on the synchronised lines.
  wire start_ev = scl_q & scl_p_q & sda_p_q & ~sda_q;
  wire stop_ev = scl_q & scl_p_q & ~sda_p_q & sda_q;
  wire scl_rise = scl_q & ~scl_p_q;
  wire scl_fall = ~scl_q & scl_p_q;
  wire [7:0] rx_byte = {shift_q[6:0], sda_q};
  wire [6:0] my_addr = {ADDR_FIXED, pins_meta_q[3:2]};
  wire addr_hit = rx_byte[7:1] == my_addr;
  wire ctrl_ok = rx_byte[7:6] == CTRL_TOP_ZERO;

  // Byte sent back for the selected channel and position.
  wire [CHAN_REG_W-1:0] rd_reg = output_channel_reg[sel_q];
  wire [7:0] pd_byte = {rd_reg[13:12], PD_BYTE_FILL};
  wire [7:0] hi_byte = rd_reg[11:4];
  wire [7:0] lo_byte = {rd_reg[3:0], LOW_NIBBLE_FILL};
  wire [7:0] tx_byte = (tx_idx_q == 2'h0) ? pd_byte :
                       (tx_idx_q == 2'h1) ? hi_byte : lo_byte;

  // Channel registers: temporary then output stage, 14 bits each.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        temp_channel_reg[i] <= '0;
        output_channel_reg[i] <= '0;
      end
    end
    else
    begin
      if (i_load_temp)
        temp_channel_reg[i_load_sel] <= i_load_value;
      if (i_load_output)
        output_channel_reg[i_load_sel] <= temp_channel_reg[i_load_sel];
    end
  end

  // Byte-level protocol engine.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      phase_q <= 2'h0;
      is_read_q <= 1'b0;
      tx_left_q <= 2'h0;
      tx_idx_q <= 2'h0;
      sda_oe_q <= 1'b0;
      sel_q <= 2'h0;
      pd_q <= 1'b0;
      load_q <= 2'h0;
    end
    else if (start_ev)
    begin
      state_q <= ST_RX;
      bit_q <= 3'h0;
      phase_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 3'h1;
          end
          if (scl_rise && bit_q == 3'h7)
          begin
            // Master code and foreign addresses draw no ack.
            if (phase_q == 2'h0 && addr_hit)
            begin
              is_read_q <= rx_byte[ADDR_RW_BIT];
              state_q <= ST_ACK;
            end
            else if (phase_q == 2'h1 && ctrl_ok)
            begin
              load_q <= rx_byte[CTRL_LOAD_LSB +: 2];
              sel_q <= rx_byte[CTRL_SEL_LSB +: 2];
              pd_q <= rx_byte[CTRL_PD_BIT];
              state_q <= ST_ACK;
            end
            else
              state_q <= ST_IGNORE;
          end
        end
        ST_ACK:
        begin
          if (scl_fall && !sda_oe_q)
            sda_oe_q <= 1'b1;
          else if (scl_fall && sda_oe_q)
          begin
            sda_oe_q <= 1'b0;
            bit_q <= 3'h0;
            if (phase_q == 2'h0 && is_read_q)
            begin
              state_q <= ST_TX;
              tx_idx_q <= pd_q ? 2'h0 : 2'h1;
              tx_left_q <= pd_q ? 2'h2 : 2'h1;
              sda_oe_q <= ~(pd_q ? pd_byte[7] : hi_byte[7]);
              phase_q <= 2'h3;
            end
            else
            begin
              state_q <= ST_RX;
              phase_q <= 2'h1;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ST_MACK;
            end
            else
              sda_oe_q <= ~tx_byte[3'h6 - bit_q];
          end
        end
        ST_MACK:
        begin
          // An ack picks the next byte; its first bit leaves on the
          // falling edge that ends the ack clock, so no bit is lost.
          if (scl_rise && (sda_q || tx_left_q == 2'h0))
            state_q <= ST_IGNORE;
          else if (scl_rise)
          begin
            tx_idx_q <= tx_idx_q + 2'h1;
            tx_left_q <= tx_left_q - 2'h1;
          end
          else if (scl_fall)
          begin
            state_q <= ST_TX;
            bit_q <= 3'h0;
            sda_oe_q <= ~tx_byte[7];
          end
        end
        // Data line stays released until the next start condition.
        ST_IGNORE: state_q <= ST_IGNORE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Slave drives data only; the clock line is never touched.
  assign bus.s_sda_oe = sda_oe_q;
  assign o_channel_sel = sel_q;
  assign o_powerdown_flag = pd_q;
  assign o_load_mode = load_q;
  assign o_reading = (state_q == ST_TX) || (state_q == ST_MACK);
endmodule : dir_slave
`default_nettype wire

// File: dir_master.sv
// Purpose: Master end that performs one readback sequence on request.
// Assumes: Single master; slave never stretches the clock.
// Notes: Optional high-speed master code precedes the sequence.
`timescale 1ns/10ps
`default_nettype none
module dir_master #(
  parameter int HALF = dir_pkg::SCL_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  dir_bus_if.master bus,
  input wire logic i_go,
  input wire logic i_hs,
  input wire logic [1:0] i_addr_pins,
  input wire logic [7:0] i_ctrl,
  output logic o_busy,
  output logic o_done,
  output logic o_nak_err,
  output logic [23:0] o_data
);
  import dir_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_START = 5'h02,
    M_BIT = 5'h04,
    M_STOP = 5'h08,
    M_DONE = 5'h10
  } dir_mstate_type;

  dir_mstate_type st_q;
  logic [1:0] meta_q;
  logic [15:0] cnt_q;
  logic [1:0] tick_q;
  logic [3:0] bit_q;
  logic [2:0] step_q;
  logic [8:0] tx_q;
  logic [23:0] data_q;
  logic [1:0] nbytes_q;
  logic scl_oe_q, sda_oe_q, nak_q, hs_q, pd_q;
  wire sda_s = meta_q[1];
  wire [6:0] addr = {ADDR_FIXED, i_addr_pins};
  wire tick = cnt_q == 16'(HALF - 1);
  // Byte sequence: code, write addr, ctrl, read addr, then reads.
  wire [7:0] code = {HS_CODE_TOP, 3'h0};

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      meta_q <= 2'h3;
    else
      meta_q <= {meta_q[0], bus.sda};
  end

  // Quarter-free timing: each phase is one half period of the clock.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= M_IDLE;
      cnt_q <= 16'h0000;
      tick_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 3'h0;
      tx_q <= 9'h000;
      data_q <= 24'h000000;
      nbytes_q <= 2'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nak_q <= 1'b0;
      hs_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (st_q == M_IDLE || tick) ? 16'h0000 : cnt_q + 16'h0001;
      case (st_q)
        M_IDLE:
        if (i_go)
        begin
          hs_q <= i_hs;
          pd_q <= i_ctrl[CTRL_PD_BIT];
          step_q <= i_hs ? 3'h0 : 3'h1;
          nak_q <= 1'b0;
          tick_q <= 2'h0;
          st_q <= M_START;
        end
        M_START:
        if (tick)
        begin
          tick_q <= tick_q + 2'h1;
          // Release both, pull data low, then clock low.
          if (tick_q == 2'h0)
            begin
              sda_oe_q <= 1'b0;
              scl_oe_q <= 1'b0;
            end
          else if (tick_q == 2'h1)
            sda_oe_q <= 1'b1;
          else
          begin
            scl_oe_q <= 1'b1;
            bit_q <= 4'h0;
            tick_q <= 2'h0;
            st_q <= M_BIT;
            case (step_q)
              3'h0: tx_q <= {code, 1'b1};
              3'h1: tx_q <= {addr, 1'b0, 1'b1};
              default: tx_q <= {addr, 1'b1, 1'b1};
            endcase
            nbytes_q <= pd_q ? 2'h3 : 2'h2;
          end
        end
        M_BIT:
        begin
          // Data moves mid-way through the low phase, clear of both edges.
          if (scl_oe_q && cnt_q == 16'(HALF / 2))
            sda_oe_q <= ~tx_q[8];
          if (tick && scl_oe_q)
            scl_oe_q <= 1'b0;
          else if (tick)
          begin
            scl_oe_q <= 1'b1;
            tx_q <= {tx_q[7:0], 1'b1};
            bit_q <= bit_q + 4'h1;
            if (step_q == 3'h4 && bit_q < 4'h8)
              data_q <= {data_q[22:0], sda_s};
            if (bit_q == 4'h8)
            begin
              bit_q <= 4'h0;
              if (step_q != 3'h0 && step_q != 3'h4 && sda_s)
              begin
                nak_q <= 1'b1;
                st_q <= M_STOP;
              end
              else if (step_q == 3'h0 || step_q == 3'h2)
              begin
                step_q <= step_q + 3'h1;
                st_q <= M_START;
              end
              else if (step_q == 3'h1)
              begin
                step_q <= 3'h2;
                tx_q <= {i_ctrl, 1'b1};
              end
              else if (step_q == 3'h3)
              begin
                // Ack bit low on every read byte but the last.
                step_q <= 3'h4;
                tx_q <= {8'hff, nbytes_q == 2'h1};
              end
              else if (nbytes_q == 2'h1)
                st_q <= M_STOP;
              else
              begin
                nbytes_q <= nbytes_q - 2'h1;
                tx_q <= {8'hff, nbytes_q == 2'h2};
              end
            end
          end
        end
        M_STOP:
        if (tick)
        begin
          tick_q <= tick_q + 2'h1;
          if (tick_q == 2'h0)
            sda_oe_q <= 1'b1;
          else if (tick_q == 2'h1)
            scl_oe_q <= 1'b0;
          else
          begin
            sda_oe_q <= 1'b0;
            tick_q <= 2'h0;
            st_q <= M_DONE;
          end
        end
        M_DONE: st_q <= M_IDLE;
        default: st_q <= M_IDLE;
      endcase
    end
  end

  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
  assign o_busy = st_q != M_IDLE;
  assign o_done = st_q == M_DONE;
  assign o_nak_err = nak_q;
  assign o_data = data_q;
endmodule : dir_master
`default_nettype wire

// File: dir_readback_chk.sv
// Purpose: Bus-level checks of the converter readback link.
// Assumes: Lines are sampled on the system clock; HALF is at least 4.
// Notes: Bytes are rebuilt from serial clock rises after each start.
`timescale 1ns/10ps
`default_nettype none
module dir_readback_chk
  import dir_pkg::*;
#(
  parameter logic [1:0] PINS = 2'h0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, rd_q, wack_q, nak_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  // Edge, start and byte decode of the resolved lines.
  wire logic rise = scl & ~scl_q;
  wire logic start = scl & scl_q & sda_q & ~sda;
  wire logic ack_rise = rise & (bit_q == 4'h8);
  wire logic addr_hit = (sh_q[7:1] == {ADDR_FIXED, PINS});
  wire logic is_code = (sh_q[7:3] == HS_CODE_TOP);
  wire logic first = ack_rise & (byte_q == 2'h0);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Rebuilds each byte and tracks its place within the transfer.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      {rd_q, wack_q, nak_q} <= 3'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        {rd_q, wack_q, nak_q} <= 3'h0;
      end
      else if (rise && !ack_rise)
      begin
        bit_q <= bit_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
      else if (ack_rise)
      begin
        bit_q <= 4'h0;
        byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
        if (byte_q == 2'h0)
        begin
          rd_q <= sh_q[0] & ~sda;
          wack_q <= ~sh_q[0] & ~sda;
        end
        if (rd_q && sda)
          nak_q <= 1'b1;
      end
    end
  end
  chk_code_no_ack: assert property (
    first && is_code |-> sda) else $error("master code was acknowledged");
  chk_waddr_ack: assert property (
    first && addr_hit && !sh_q[0] |-> !sda) else $error("write address nak");
  chk_raddr_ack: assert property (
    first && addr_hit && sh_q[0] |-> !sda) else $error("read address nak");
  chk_foreign_no_ack: assert property (
    first && !addr_hit && !is_code |-> sda) else $error("foreign ack");
  chk_ctrl_ack: assert property (
    ack_rise && byte_q == 2'h1 && wack_q && sh_q[7:6] == CTRL_TOP_ZERO
    |-> !sda) else $error("control byte not acknowledged");
  chk_ctrl_top_nak: assert property (
    ack_rise && byte_q == 2'h1 && wack_q && sh_q[7:6] != CTRL_TOP_ZERO
    |-> sda) else $error("bad control byte acknowledged");
  chk_nak_release: assert property (
    nak_q |-> !s_sda_oe) else $error("slave drove data after master nak");
  chk_no_clock_hold: assert property (
    !m_scl_oe |-> scl) else $error("serial clock held low");
  chk_data_moves_low: assert property (
    $changed(s_sda_oe) |-> !scl && !$past(scl))
    else $error("slave changed data while clock high");
  cov_code: cover property (first && is_code);
  cov_ctrl: cover property (ack_rise && byte_q == 2'h1 && wack_q && !sda);
  cov_read_end: cover property (ack_rise && rd_q && sda);
endmodule : dir_readback_chk
`default_nettype wire

// File: dir_slave_bench.sv
// Purpose: Self-checking bench joining master and slave ends.
// Assumes: Shortened half period of 8 clock cycles.
// Notes: Readbacks cover every channel, both flag values, with and without the master code.
`timescale 1ns/10ps
`default_nettype none
module dir_slave_bench;
  import dir_pkg::*;
  localparam logic [1:0] PINS = 2'h2;
  logic i_clk_sys, i_rst_n, i_go, i_hs, i_load_temp, i_load_output;
  logic [1:0] i_addr_pins, i_load_sel, o_channel_sel, o_load_mode;
  logic [7:0] i_ctrl;
  logic [13:0] i_load_value;
  logic o_busy, o_done, o_nak_err, o_powerdown_flag, o_reading;
  logic [23:0] o_data;
  logic [13:0] chan_val [4];
  int error_cnt, checks_done;
  dir_bus_if dir_bus_if_i ();
  dir_slave dir_slave_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .bus(dir_bus_if_i), .i_addr_pin_hi(PINS[1]), .i_addr_pin_lo(PINS[0]),
    .i_load_sel(i_load_sel), .i_load_temp(i_load_temp),
    .i_load_output(i_load_output), .i_load_value(i_load_value),
    .o_channel_sel(o_channel_sel), .o_powerdown_flag(o_powerdown_flag),
    .o_load_mode(o_load_mode), .o_reading(o_reading));
  dir_master #(.HALF(8)) dir_master_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .bus(dir_bus_if_i), .i_go(i_go), .i_hs(i_hs),
    .i_addr_pins(i_addr_pins), .i_ctrl(i_ctrl), .o_busy(o_busy),
    .o_done(o_done), .o_nak_err(o_nak_err), .o_data(o_data));
  dir_readback_chk #(.PINS(PINS)) chk_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .m_scl_oe(dir_bus_if_i.m_scl_oe),
    .m_sda_oe(dir_bus_if_i.m_sda_oe), .s_sda_oe(dir_bus_if_i.s_sda_oe),
    .scl(dir_bus_if_i.scl), .sda(dir_bus_if_i.sda));
  // Free-running system clock.
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Writes a channel's temporary register and optionally copies it out.
  task automatic load(input logic [1:0] ch, input logic [13:0] val,
                      input logic copy);
    i_load_sel <= ch;
    i_load_value <= val;
    i_load_temp <= 1'b1;
    @(posedge i_clk_sys);
    i_load_temp <= 1'b0;
    i_load_output <= copy;
    @(posedge i_clk_sys);
    i_load_output <= 1'b0;
    @(posedge i_clk_sys);
  endtask : load
  // Starts one sequence and waits, bounded, for the master to go idle.
  task automatic run(input logic hs, input logic [1:0] pins,
                     input logic [7:0] ctrl, input logic exp_rd);
    int n;
    logic rd_seen;
    logic done_seen;
    n = 0;
    rd_seen = 1'b0;
    done_seen = 1'b0;
    i_hs <= hs;
    i_addr_pins <= pins;
    i_ctrl <= ctrl;
    i_go <= 1'b1;
    @(posedge i_clk_sys);
    i_go <= 1'b0;
    @(negedge i_clk_sys);
    check("busy", 24'h1, {23'h0, o_busy});
    while (o_busy === 1'b1 && n < 20000)
    begin
      rd_seen = rd_seen | (o_reading === 1'b1);
      done_seen = done_seen | (o_done === 1'b1);
      @(negedge i_clk_sys);
      n++;
    end
    check("finished", 24'h1, {23'h0, n < 20000});
    check("done pulse", 24'h1, {23'h0, done_seen});
    check("reading", {23'h0, exp_rd}, {23'h0, rd_seen});
    @(posedge i_clk_sys);
  endtask : run
  // One readback with expectations built from the stored channel value.
  task automatic rb(input logic hs, input logic [1:0] ch, input logic pd,
                    input logic [1:0] mode);
    logic [13:0] v;
    logic [23:0] exp;
    v = chan_val[ch];
    exp = pd ? {v[13:12], PD_BYTE_FILL, v[11:0], LOW_NIBBLE_FILL}
             : {8'h00, v[11:0], LOW_NIBBLE_FILL};
    run(hs, PINS, {CTRL_TOP_ZERO, mode, hs, ch, pd}, 1'b1);
    check("readback", exp,
          pd ? o_data : {8'h00, o_data[15:0]});
    check("control", {19'h0, ch, pd, mode},
          {19'h0, o_channel_sel, o_powerdown_flag, o_load_mode});
    check("nak", 24'h0, {23'h0, o_nak_err});
  endtask : rb
  // Cuts a hung run short.
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    end_of_test();
  end
  // Main sequence: loads, readbacks, refusals and recovery.
  initial
  begin
    {i_rst_n, i_go, i_hs, i_load_temp, i_load_output} = 5'h0;
    {i_addr_pins, i_load_sel, i_ctrl, i_load_value} = 26'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    for (int c = 0; c < 4; c++)
    begin
      chan_val[c] = {2'(3 - c), 12'(12'h8c1 + 12'h247 * c)};
      load(2'(c), chan_val[c], 1'b1);
    end
    for (int i = 0; i < 8; i++)
      rb(i[1], 2'(i), i[2], 2'(i + 1));
    load(2'h0, 14'h0123, 1'b0);
    rb(1'b0, 2'h0, 1'b1, 2'h3);
    run(1'b0, ~PINS, 8'h01, 1'b0);
    check("foreign nak", 24'h1, {23'h0, o_nak_err});
    run(1'b0, PINS, 8'h41, 1'b0);
    check("ctrl nak", 24'h1, {23'h0, o_nak_err});
    rb(1'b1, 2'h3, 1'b1, 2'h0);
    end_of_test();
  end
endmodule : dir_slave_bench
`default_nettype wire
